// ### hdl/acc_top.sv
/*
 * Comparator control: APB registers, enable gating, result sync,
 * change interrupt and pin output steering.
 * Assumes the comparator output is asynchronous and the analog pad
 * configuration comes from a fixed configuration word input.
 */
module acc_top (
	input wire logic mclk_i, // System clock
	input wire logic rstn_i, // Async reset, active low
	input wire logic psel_i, // APB select
	input wire logic penable_i, // APB enable
	input wire logic pwrite_i, // APB write
	input wire logic [11:0] paddr_i, // APB address
	input wire logic [31:0] pwdata_i, // APB write data
	output logic [31:0] prdata_o, // APB read data
	output logic pready_o, // APB ready
	output logic pslverr_o, // APB error
	input wire logic halt_mode_i, // Device in halt mode
	input wire logic global_irq_enable_i, // Global interrupt enable
	input wire logic [13:0] analog_pad_cfg_i, // Configuration word pad mask
	input wire logic comparator_raw_i, // Async comparator output
	input wire logic first_pulse_width_output_en_i, // Software PWM enable
	output logic comparator_enable_o, // Comparator power enable
	output logic [3:0] noninv_pad_o, // Non-inverting pad code
	output logic [3:0] inv_pad_o, // Inverting pad code
	output logic inv_from_ladder_o, // Inverting from ladder
	output logic [3:0] ladder_tap_o, // Ladder tap code
	output logic [13:0] pad_analog_mode_o, // Pads in analog mode
	output logic port_b_pin3_o, // Pin data
	output logic port_b_pin3_oe_o, // Pin output enable
	output logic first_pulse_width_output_en_o, // Gated PWM enable
	output logic comparator_irq_o // Interrupt request
);
	typedef struct packed {
		logic [7:0] analog_enable_reg;
		logic [7:0] comparator_control_reg;
		logic comparator_pin_output_enable;
		logic sync1;
		logic sync2;
		logic snapshot;
		logic comparator_irq_flag;
		logic comparator_irq_enable;
		logic rd_done;
		logic [31:0] rdata;
	} acc_state_s;

	acc_state_s cur;
	acc_state_s next_cur;
	logic wr;
	logic rd;
	logic p2p;

	assign wr = psel_i && penable_i && pwrite_i;
	assign rd = psel_i && penable_i && !pwrite_i;

	acc_pad_mux u_mux (
		.reference_select_i(cur.comparator_control_reg[acc_pkg::REF_SEL_LSB +: 4]),
		.pad_select_i(cur.comparator_control_reg[acc_pkg::PAD_SEL_LSB +: 4]),
		.noninv_pad_o(noninv_pad_o),
		.inv_pad_o(inv_pad_o),
		.inv_from_ladder_o(inv_from_ladder_o),
		.ladder_tap_o(ladder_tap_o),
		.pad_to_pad_mode_o(p2p)
	);

	always_comb begin
		next_cur = cur;
		next_cur.sync1 = comparator_raw_i;
		next_cur.sync2 = cur.sync1;
		if (wr) begin
			case (paddr_i)
				acc_pkg::ANALOG_ENABLE_OFF: next_cur.analog_enable_reg = pwdata_i[7:0];
				acc_pkg::CONTROL_OFF: next_cur.comparator_control_reg = pwdata_i[7:0];
				acc_pkg::STATUS_OFF:
					next_cur.comparator_pin_output_enable = pwdata_i[acc_pkg::PIN_OE_BIT];
				acc_pkg::IRQ_ENABLE_OFF:
					next_cur.comparator_irq_enable = pwdata_i[acc_pkg::IRQ_CHANGE_BIT];
				acc_pkg::IRQ_CLEAR_OFF: begin
					if (pwdata_i[acc_pkg::IRQ_CHANGE_BIT]) begin
						next_cur.comparator_irq_flag = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		if (rd && paddr_i == acc_pkg::STATUS_OFF) begin
			next_cur.snapshot = cur.sync2;
		end
		if (cur.sync2 != cur.snapshot && comparator_enable_o) begin
			next_cur.comparator_irq_flag = 1'b1;
		end
		// Second access cycle of a read presents the registered data
		next_cur.rd_done = rd && !cur.rd_done;
		next_cur.rdata = 32'h0000_0000;
		if (rd) begin
			case (paddr_i)
				acc_pkg::ANALOG_ENABLE_OFF: next_cur.rdata[7:0] = cur.analog_enable_reg;
				acc_pkg::CONTROL_OFF: next_cur.rdata[7:0] = cur.comparator_control_reg;
				acc_pkg::STATUS_OFF: begin
					next_cur.rdata[acc_pkg::RESULT_BIT] = cur.sync2;
					next_cur.rdata[acc_pkg::PIN_OE_BIT] = cur.comparator_pin_output_enable;
				end
				acc_pkg::IRQ_STATUS_OFF:
					next_cur.rdata[acc_pkg::IRQ_CHANGE_BIT] = cur.comparator_irq_flag;
				acc_pkg::IRQ_ENABLE_OFF:
					next_cur.rdata[acc_pkg::IRQ_CHANGE_BIT] = cur.comparator_irq_enable;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cur <= '{analog_enable_reg: acc_pkg::ANALOG_ENABLE_RST,
				comparator_control_reg: acc_pkg::CONTROL_RST,
				comparator_pin_output_enable: acc_pkg::PIN_OE_RST,
				default: '0};
		end else begin
			cur <= next_cur;
		end
	end

	always_comb begin
		pslverr_o = 1'b0;
		if (psel_i && penable_i) begin
			case (paddr_i)
				acc_pkg::ANALOG_ENABLE_OFF, acc_pkg::CONTROL_OFF, acc_pkg::STATUS_OFF,
				acc_pkg::IRQ_ENABLE_OFF: pslverr_o = 1'b0;
				acc_pkg::IRQ_STATUS_OFF: pslverr_o = pwrite_i;
				acc_pkg::IRQ_CLEAR_OFF: pslverr_o = !pwrite_i;
				default: pslverr_o = 1'b1;
			endcase
		end
	end

	// Read data is registered, so reads take one wait state
	assign pready_o = pwrite_i || !penable_i || cur.rd_done;
	assign prdata_o = cur.rdata;

	assign comparator_enable_o = cur.analog_enable_reg[acc_pkg::CMP_EN_BIT] && !halt_mode_i;
	assign pad_analog_mode_o = analog_pad_cfg_i;
	assign port_b_pin3_oe_o = cur.comparator_pin_output_enable;
	assign port_b_pin3_o = cur.sync2;
	assign first_pulse_width_output_en_o = first_pulse_width_output_en_i
		&& !cur.comparator_pin_output_enable;
	assign comparator_irq_o = cur.comparator_irq_flag && cur.comparator_irq_enable
		&& global_irq_enable_i;
endmodule

// ### include/acc_pkg.sv
/*
 * Constants for the comparator control block: register offsets, field
 * positions, reset values and the pad numbering used by the selectors.
 * Assumes an APB master with 32-bit data and word-aligned accesses.
 */
// What this block does
// - Comparator enabled only while enable bit set
// - Halt mode forces the comparator off
// - Reference code zero pad pair, else reference
// - Nonzero code k selects ladder tap k/16
// - Ladder reaches only the inverting input
// - Reference mode pad codes: A0-7, B0-5, none
// - Pad pairs for codes 0-3 and 12-15
// - Cross-port pad pairs for codes 4-11
// - Status read copies live result to snapshot
// - Result differing from snapshot sets flag while comparator enabled
// - Result readable at status bit 7
// - Pin output bit drives port B pin3
// - Pin output blocks first pulse width output
// - Analog pad mode from configuration word only
// - Request needs flag, enable and global enable
package acc_pkg;
	localparam logic [11:0] ANALOG_ENABLE_OFF = 12'h000;
	localparam logic [11:0] CONTROL_OFF = 12'h004;
	localparam logic [11:0] STATUS_OFF = 12'h008;
	localparam logic [11:0] IRQ_STATUS_OFF = 12'h00C;
	localparam logic [11:0] IRQ_ENABLE_OFF = 12'h010;
	localparam logic [11:0] IRQ_CLEAR_OFF = 12'h014;
	localparam int CMP_EN_BIT = 7;
	localparam int REF_SEL_LSB = 0;
	localparam int PAD_SEL_LSB = 4;
	localparam int RESULT_BIT = 7;
	localparam int PIN_OE_BIT = 6;
	localparam int IRQ_CHANGE_BIT = 0;
	localparam logic [7:0] ANALOG_ENABLE_RST = 8'h00;
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic PIN_OE_RST = 1'b0;
	// Pad numbering on the mux select: port A 0..7, port B 8..13, 15 = none
	localparam logic [3:0] PAD_A0 = 4'h0;
	localparam logic [3:0] PAD_B0 = 4'h8;
	localparam logic [3:0] PAD_NONE = 4'hF;
endpackage

// ### hdl/acc_pad_mux.sv
/*
 * Decodes the pad and reference selects into the analog mux codes.
 * Assumes the analog macro treats code 15 as an open input.
 */
module acc_pad_mux (
	input wire logic [3:0] reference_select_i, // Reference select field
	input wire logic [3:0] pad_select_i, // Pad select field
	output logic [3:0] noninv_pad_o, // Non-inverting pad code
	output logic [3:0] inv_pad_o, // Inverting pad code
	output logic inv_from_ladder_o, // Inverting input from ladder
	output logic [3:0] ladder_tap_o, // Ladder tap in sixteenths
	output logic pad_to_pad_mode_o // High in pad pair mode
);
	function automatic logic [3:0] pa(input logic [3:0] n);
		pa = acc_pkg::PAD_A0 + n;
	endfunction
	function automatic logic [3:0] pb(input logic [3:0] n);
		pb = acc_pkg::PAD_B0 + n;
	endfunction

	always_comb begin
		pad_to_pad_mode_o = (reference_select_i == 4'h0);
		inv_from_ladder_o = !pad_to_pad_mode_o;
		ladder_tap_o = reference_select_i;
		noninv_pad_o = acc_pkg::PAD_NONE;
		inv_pad_o = acc_pkg::PAD_NONE;
		if (!pad_to_pad_mode_o) begin
			if (pad_select_i < 4'hE) begin
				noninv_pad_o = pad_select_i;
			end
		end else begin
			case (pad_select_i)
				4'h0: begin noninv_pad_o = pa(4'h0); inv_pad_o = pa(4'h1); end
				4'h1: begin noninv_pad_o = pa(4'h1); inv_pad_o = pa(4'h0); end
				4'h2: begin noninv_pad_o = pa(4'h2); inv_pad_o = pa(4'h3); end
				4'h3: begin noninv_pad_o = pa(4'h3); inv_pad_o = pa(4'h2); end
				4'h4: begin noninv_pad_o = pa(4'h0); inv_pad_o = pb(4'h3); end
				4'h5: begin noninv_pad_o = pa(4'h1); inv_pad_o = pb(4'h2); end
				4'h6: begin noninv_pad_o = pa(4'h2); inv_pad_o = pb(4'h5); end
				4'h7: begin noninv_pad_o = pa(4'h3); inv_pad_o = pb(4'h4); end
				4'h8: begin noninv_pad_o = pb(4'h2); inv_pad_o = pa(4'h1); end
				4'h9: begin noninv_pad_o = pb(4'h3); inv_pad_o = pa(4'h0); end
				4'hA: begin noninv_pad_o = pb(4'h4); inv_pad_o = pa(4'h3); end
				4'hB: begin noninv_pad_o = pb(4'h5); inv_pad_o = pa(4'h2); end
				4'hC: begin noninv_pad_o = pb(4'h2); inv_pad_o = pb(4'h3); end
				4'hD: begin noninv_pad_o = pb(4'h3); inv_pad_o = pb(4'h2); end
				4'hE: begin noninv_pad_o = pb(4'h4); inv_pad_o = pb(4'h5); end
				default: begin noninv_pad_o = pb(4'h5); inv_pad_o = pb(4'h4); end
			endcase
		end
	end
endmodule

// ### testbench/acc_top_asserts.sv
/* Port checker for acc_top. Assumes binding to acc_top, one clock domain. */
module acc_top_asserts (
	input wire logic mclk_i, // Clock
	input wire logic rstn_i, // Reset
	input wire logic psel_i, // Select
	input wire logic pwrite_i, // Write
	input wire logic halt_mode_i, // Halt
	input wire logic global_irq_enable_i, // Global enable
	input wire logic [13:0] analog_pad_cfg_i, // Pad word
	input wire logic comparator_raw_i, // Raw result
	input wire logic first_pulse_width_output_en_i, // PWM in
	input wire logic comparator_enable_o, // Enable
	input wire logic inv_from_ladder_o, // Ladder
	input wire logic [3:0] ladder_tap_o, // Tap
	input wire logic [13:0] pad_analog_mode_o, // Analog pads
	input wire logic port_b_pin3_o, // Pin
	input wire logic port_b_pin3_oe_o, // Pin enable
	input wire logic first_pulse_width_output_en_o, // PWM out
	input wire logic comparator_irq_o // Request
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	halt_off_a: assert property (halt_mode_i [*2] |-> !comparator_enable_o)
		else $error("comparator on in halt");
	ladder_tap_a: assert property (inv_from_ladder_o |-> ladder_tap_o != 4'h0)
		else $error("ladder with zero tap");
	irq_gate_a: assert property (!global_irq_enable_i |-> !comparator_irq_o)
		else $error("request without global enable");
	pwm_block_a: assert property (port_b_pin3_oe_o |-> !first_pulse_width_output_en_o)
		else $error("pwm not blocked");
	pwm_pass_a: assert property (!port_b_pin3_oe_o |->
		first_pulse_width_output_en_o == first_pulse_width_output_en_i)
		else $error("pwm enable lost");
	cfg_pad_a: assert property ($stable(analog_pad_cfg_i) [*3] |->
		pad_analog_mode_o == analog_pad_cfg_i)
		else $error("analog pads differ from word");
	pin_live_a: assert property ((port_b_pin3_oe_o && $stable(comparator_raw_i)) [*4] |->
		port_b_pin3_o == comparator_raw_i)
		else $error("pin not following result");
	flag_hold_a: assert property (comparator_irq_o && !(psel_i && pwrite_i) ##1
		global_irq_enable_i |-> comparator_irq_o)
		else $error("request dropped without write");
	cover property ($rose(comparator_irq_o));
	cover property ($rose(port_b_pin3_oe_o));
	cover property ($rose(inv_from_ladder_o));
endmodule
bind acc_top acc_top_asserts i_chk (.*);

// ### testbench/acc_cmp_model.sv
/* Comparator macro model. Assumes levels in sixteenths of supply; pad 15 open. */
module acc_cmp_model (
	input wire logic enable_i, // Powered
	input wire logic [3:0] noninv_pad_i, // Plus pad
	input wire logic [3:0] inv_pad_i, // Minus pad
	input wire logic inv_from_ladder_i, // Ladder on minus
	input wire logic [3:0] ladder_tap_i, // Tap
	input wire logic [15:0][4:0] pad_level_i, // Pad levels
	output logic result_o // Raw result
);
	logic [4:0] vp;
	logic [4:0] vn;
	assign vp = pad_level_i[noninv_pad_i];
	assign vn = inv_from_ladder_i ? {1'b0, ladder_tap_i} : pad_level_i[inv_pad_i];
	assign result_o = enable_i && (vp > vn);
endmodule

// ### testbench/test_analog_comparator_control.sv
/* Bench for acc_top. Assumes acc_pkg and the comparator model. */
module test_analog_comparator_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, halt_mode_i = 0;
	logic global_irq_enable_i = 0, first_pulse_width_output_en_i = 1;
	logic [11:0] paddr_i = 0;
	logic [31:0] pwdata_i = 0, prdata_o, q;
	logic [13:0] analog_pad_cfg_i = 14'h2A55, pad_analog_mode_o;
	logic [15:0][4:0] lvl = '0;
	logic [3:0] noninv_pad_o, inv_pad_o, ladder_tap_o;
	logic pready_o, pslverr_o, comparator_raw_i, comparator_enable_o, inv_from_ladder_o;
	logic port_b_pin3_o, port_b_pin3_oe_o, first_pulse_width_output_en_o, comparator_irq_o;
	int mismatches = 0, compares = 0;
	acc_top i_dut (.*);
	acc_cmp_model i_cmp (.enable_i(comparator_enable_o), .noninv_pad_i(noninv_pad_o),
		.inv_pad_i(inv_pad_o), .inv_from_ladder_i(inv_from_ladder_o),
		.ladder_tap_i(ladder_tap_o), .pad_level_i(lvl), .result_o(comparator_raw_i));
	initial forever #2.5 mclk_i = ~mclk_i;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge mclk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		if (pready_o !== 1'b1) begin
			mismatches++;
			print_verdict();
		end
		q = prdata_o;
		chk(pslverr_o, 0);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(negedge mclk_i);
	endtask
	task automatic settle(input int c);
		repeat (c) @(negedge mclk_i);
	endtask
	task automatic t_reset_enable;
		chk(comparator_enable_o, 0);
		chk(pad_analog_mode_o, 14'h2A55);
		apb(0, acc_pkg::CONTROL_OFF, 0);
		chk(q, acc_pkg::CONTROL_RST);
		apb(1, acc_pkg::ANALOG_ENABLE_OFF, 32'h0000_0080);
		settle(1);
		chk(comparator_enable_o, 1);
		@(posedge mclk_i) halt_mode_i <= 1'b1;
		settle(3);
		chk(comparator_enable_o, 0);
		@(posedge mclk_i) halt_mode_i <= 1'b0;
	endtask
	task automatic t_mux;
		logic [63:0] pp;
		logic [63:0] pn;
		logic [3:0] p;
		pp = 64'hDCBA_DCBA_3210_3210;
		pn = 64'hCDAB_2301_CDAB_2301;
		for (int i = 0; i < 16; i++) begin
			apb(1, acc_pkg::CONTROL_OFF, i << 4);
			chk({inv_from_ladder_o, noninv_pad_o, inv_pad_o}, {1'b0, pp[i*4+:4], pn[i*4+:4]});
		end
		for (int k = 1; k < 16; k++) begin
			p = 4'(k - 1);
			apb(1, acc_pkg::CONTROL_OFF, {p, 4'(k)});
			chk({inv_from_ladder_o, ladder_tap_o, noninv_pad_o},
				{1'b1, 4'(k), p > 13 ? acc_pkg::PAD_NONE : p});
		end
	endtask
	task automatic t_irq_pin;
		apb(1, acc_pkg::CONTROL_OFF, 32'h0000_0008);
		apb(1, acc_pkg::IRQ_ENABLE_OFF, 1);
		@(posedge mclk_i) global_irq_enable_i <= 1'b1;
		apb(0, acc_pkg::STATUS_OFF, 0);
		apb(1, acc_pkg::IRQ_CLEAR_OFF, 1);
		chk(comparator_irq_o, 0);
		@(posedge mclk_i) lvl[0] <= 5'd12;
		settle(8);
		chk(comparator_irq_o, 1);
		apb(0, acc_pkg::STATUS_OFF, 0);
		chk(q[acc_pkg::RESULT_BIT], 1);
		chk(comparator_irq_o, 1);
		@(posedge mclk_i) global_irq_enable_i <= 1'b0;
		settle(1);
		chk(comparator_irq_o, 0);
		@(posedge mclk_i) global_irq_enable_i <= 1'b1;
		apb(1, acc_pkg::IRQ_CLEAR_OFF, 1);
		apb(1, acc_pkg::IRQ_ENABLE_OFF, 0);
		@(posedge mclk_i) lvl[0] <= 5'd0;
		settle(8);
		chk(comparator_irq_o, 0);
		apb(0, acc_pkg::IRQ_STATUS_OFF, 0);
		chk(q[acc_pkg::IRQ_CHANGE_BIT], 1);
		apb(1, acc_pkg::STATUS_OFF, 1 << acc_pkg::PIN_OE_BIT);
		settle(4);
		chk({port_b_pin3_oe_o, port_b_pin3_o, first_pulse_width_output_en_o}, 3'b100);
		@(posedge mclk_i) lvl[0] <= 5'd12;
		settle(6);
		chk(port_b_pin3_o, 1);
	endtask
	initial begin
		repeat (10) @(posedge mclk_i);
		rstn_i <= 1'b1;
		t_reset_enable();
		t_mux();
		t_irq_pin();
		print_verdict();
	end
endmodule
